/* File: core/aocc_pkg.sv */
// constants and types of the adc output and clock configuration register bank
package aocc_pkg;

    // register access and sample port widths
    localparam int unsigned AOCC_ADDR_W = 13;
    localparam int unsigned AOCC_DATA_W = 8;
    localparam int unsigned AOCC_SMP_W  = 14;

    // register offsets
    localparam logic [12:0] AOCC_ADR_SELF_TEST  = 13'h000e;
    localparam logic [12:0] AOCC_ADR_SERVO      = 13'h000f;
    localparam logic [12:0] AOCC_ADR_OFFSET     = 13'h0010;
    localparam logic [12:0] AOCC_ADR_OUT_MODE   = 13'h0014;
    localparam logic [12:0] AOCC_ADR_CLK_PHASE  = 13'h0016;
    localparam logic [12:0] AOCC_ADR_CLK_DELAY  = 13'h0017;
    localparam logic [12:0] AOCC_ADR_REF_RANGE  = 13'h0018;
    localparam logic [12:0] AOCC_ADR_SIG_LOW    = 13'h0024;

    // reset values
    localparam logic [7:0] AOCC_RST_SELF_TEST = 8'h04;
    localparam logic [7:0] AOCC_RST_SERVO     = 8'h00;
    localparam logic [7:0] AOCC_RST_OFFSET    = 8'h00;
    localparam logic [7:0] AOCC_RST_OUT_MODE  = 8'h00;
    localparam logic [7:0] AOCC_RST_CLK_PHASE = 8'h00;
    localparam logic [7:0] AOCC_RST_CLK_DELAY = 8'h00;
    localparam logic [7:0] AOCC_RST_REF_RANGE = 8'hc0;

    // writable bit masks, open bits read as zero
    localparam logic [7:0] AOCC_MSK_SELF_TEST = 8'h05;
    localparam logic [7:0] AOCC_MSK_SERVO     = 8'h01;
    localparam logic [7:0] AOCC_MSK_OUT_MODE  = 8'hff;
    localparam logic [7:0] AOCC_MSK_CLK_PHASE = 8'h87;
    localparam logic [7:0] AOCC_MSK_CLK_DELAY = 8'h1f;
    localparam logic [7:0] AOCC_MSK_REF_RANGE = 8'hc0;

    // field positions
    localparam int unsigned AOCC_BIT_TEST_EN    = 0;
    localparam int unsigned AOCC_BIT_TEST_RST   = 2;
    localparam int unsigned AOCC_BIT_SERVO_EN   = 0;
    localparam int unsigned AOCC_BIT_INVERT     = 2;
    localparam int unsigned AOCC_BIT_OUT_OFF    = 4;
    localparam int unsigned AOCC_BIT_INTERLEAVE = 5;
    localparam int unsigned AOCC_BIT_OUT_TYPE   = 6;
    localparam int unsigned AOCC_BIT_DRIVE      = 7;
    localparam int unsigned AOCC_BIT_DCLK_INV   = 7;
    localparam int unsigned AOCC_FMT_LSB        = 0;
    localparam int unsigned AOCC_PHASE_LSB      = 0;
    localparam int unsigned AOCC_DELAY_LSB      = 0;
    localparam int unsigned AOCC_REF_LSB        = 6;

    // output data formats
    typedef enum logic [1:0] {
        AOCC_FMT_OFFSET_BIN  = 2'h0,
        AOCC_FMT_TWOS        = 2'h1,
        AOCC_FMT_GRAY        = 2'h2,
        AOCC_FMT_OFFSET_BIN2 = 2'h3
    } aocc_fmt_type;

    // output data clock delay scaling
    localparam int unsigned AOCC_DCLK_FULL_PS = 2500;
    localparam int unsigned AOCC_DCLK_STEPS   = 31;
    localparam int unsigned AOCC_DCLK_PS_W    = 12;

    // clock divider phase taps
    localparam int unsigned AOCC_PHASE_TAPS = 7;

    // signature feedback polynomial taps
    localparam logic [15:0] AOCC_SIG_POLY = 16'h002d;

endpackage : aocc_pkg

/* File: core/aocc_regs.sv */
// adc output and clock configuration register bank with its data formatting path
`timescale 1ns/1ns
`default_nettype none

module aocc_regs
    import aocc_pkg::*;
(
    // clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_n_i,
    // register access from the serial port front end
    input  wire logic [AOCC_ADDR_W-1:0]    reg_addr_i,
    input  wire logic [AOCC_DATA_W-1:0]    reg_wdata_i,
    input  wire logic                      reg_wr_i,
    input  wire logic                      reg_rd_i,
    output logic      [AOCC_DATA_W-1:0]    reg_rdata_o,
    // converter samples, offset binary
    input  wire logic [AOCC_SMP_W-1:0]     sample_i,
    output logic      [AOCC_SMP_W-1:0]     data_o,
    // output driver control
    input  wire logic                      output_disable_pin_i,
    output logic                           outputs_enable_o,
    output logic                           lvds_mode_o,
    output logic                           reduced_swing_o,
    output logic                           interleave_o,
    // clock path
    input  wire logic                      div_tick_i,
    output logic                           div_tick_o,
    output logic                           output_data_clock_invert_o,
    output logic      [AOCC_DCLK_PS_W-1:0] output_data_clock_delay_ps_o,
    // analog controls
    output logic                           servo_enable_o,
    output logic      [1:0]                ref_range_o
);

    logic [7:0]  self_test_r;
    logic [7:0]  servo_r;
    logic [7:0]  offset_r;
    logic [7:0]  out_mode_r;
    logic [7:0]  clk_phase_r;
    logic [7:0]  clk_delay_r;
    logic [7:0]  ref_range_r;
    logic [15:0] sig_r;
    logic [15:0] sig_nxt;
    logic [7:0]  rdata_nxt;
    logic        pin_meta_r;
    logic        pin_sync_r;
    logic [AOCC_PHASE_TAPS-1:0] tap_r;
    logic [2:0]  phase;
    logic signed [14:0] trim_sum;
    logic signed [13:0] trim_sat;
    logic [13:0] code_twos;
    logic [13:0] code_ob;
    logic [13:0] data_nxt;
    aocc_fmt_type fmt;

    // register writes; bit 3 of output mode is stored but steers nothing
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            self_test_r <= AOCC_RST_SELF_TEST;
            servo_r     <= AOCC_RST_SERVO;
            offset_r    <= AOCC_RST_OFFSET;
            out_mode_r  <= AOCC_RST_OUT_MODE;
            clk_phase_r <= AOCC_RST_CLK_PHASE;
            clk_delay_r <= AOCC_RST_CLK_DELAY;
            ref_range_r <= AOCC_RST_REF_RANGE;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                AOCC_ADR_SELF_TEST: self_test_r <= reg_wdata_i & AOCC_MSK_SELF_TEST;
                AOCC_ADR_SERVO:     servo_r     <= reg_wdata_i & AOCC_MSK_SERVO;
                AOCC_ADR_OFFSET:    offset_r    <= reg_wdata_i;
                AOCC_ADR_OUT_MODE:  out_mode_r  <= reg_wdata_i & AOCC_MSK_OUT_MODE;
                AOCC_ADR_CLK_PHASE: clk_phase_r <= reg_wdata_i & AOCC_MSK_CLK_PHASE;
                AOCC_ADR_CLK_DELAY: clk_delay_r <= reg_wdata_i & AOCC_MSK_CLK_DELAY;
                AOCC_ADR_REF_RANGE: ref_range_r <= reg_wdata_i & AOCC_MSK_REF_RANGE;
                default: ; // read-only and unmapped writes are dropped
            endcase
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        unique case (reg_addr_i)
            AOCC_ADR_SELF_TEST: rdata_nxt = self_test_r;
            AOCC_ADR_SERVO:     rdata_nxt = servo_r;
            AOCC_ADR_OFFSET:    rdata_nxt = offset_r;
            AOCC_ADR_OUT_MODE:  rdata_nxt = out_mode_r;
            AOCC_ADR_CLK_PHASE: rdata_nxt = clk_phase_r;
            AOCC_ADR_CLK_DELAY: rdata_nxt = clk_delay_r;
            AOCC_ADR_REF_RANGE: rdata_nxt = ref_range_r;
            AOCC_ADR_SIG_LOW:   rdata_nxt = sig_r[7:0];
            default:            rdata_nxt = 8'h00;
        endcase
    end

    // read data held until the next read
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 8'h00;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_nxt;
        end
    end

    // the disable pin is asynchronous to the converter clock
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pin_meta_r <= 1'b1;
            pin_sync_r <= 1'b1;
        end else begin
            pin_meta_r <= output_disable_pin_i;
            pin_sync_r <= pin_meta_r;
        end
    end

    // driver controls from the registers; output enable is also gated by the synced disable pin
    assign outputs_enable_o           = ~pin_sync_r & ~out_mode_r[AOCC_BIT_OUT_OFF];
    assign lvds_mode_o                = out_mode_r[AOCC_BIT_OUT_TYPE];
    assign reduced_swing_o            = out_mode_r[AOCC_BIT_DRIVE];
    assign interleave_o               = out_mode_r[AOCC_BIT_INTERLEAVE];
    assign output_data_clock_invert_o = clk_phase_r[AOCC_BIT_DCLK_INV];
    assign servo_enable_o             = servo_r[AOCC_BIT_SERVO_EN];
    assign ref_range_o                = ref_range_r[AOCC_REF_LSB +: 2];

    // divider phase: a tapped delay line, phase 0 is the undelayed tick
    assign phase = clk_phase_r[AOCC_PHASE_LSB +: 3];
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tap_r <= '0;
        end else begin
            tap_r <= {tap_r[AOCC_PHASE_TAPS-2:0], div_tick_i};
        end
    end
    assign div_tick_o = (phase == 3'h0) ? div_tick_i : tap_r[phase - 3'h1];

    // output clock delay in picoseconds, rounded to the nearest ps so code 1 reports 81;
    // the divide is by a constant so it folds to logic
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            output_data_clock_delay_ps_o <= '0;
        end else begin
            output_data_clock_delay_ps_o <= AOCC_DCLK_PS_W'(
                (17'(clk_delay_r[AOCC_DELAY_LSB +: 5]) * 17'(AOCC_DCLK_FULL_PS)
                 + 17'(AOCC_DCLK_STEPS / 2)) / 17'(AOCC_DCLK_STEPS));
        end
    end

    // trim in twos complement space, saturating so a trim never wraps full scale
    always_comb begin
        trim_sum = 15'(signed'({~sample_i[13], sample_i[12:0]}))
                 + 15'(signed'(offset_r));
        if (trim_sum > 15'sd8191) begin
            trim_sat = 14'sh1fff;
        end else if (trim_sum < -15'sd8192) begin
            trim_sat = 14'sh2000;
        end else begin
            trim_sat = trim_sum[13:0];
        end
    end

    // invert then encode
    assign fmt       = aocc_fmt_type'(out_mode_r[AOCC_FMT_LSB +: 2]);
    assign code_twos = out_mode_r[AOCC_BIT_INVERT] ? ~trim_sat : trim_sat;
    assign code_ob   = {~code_twos[13], code_twos[12:0]};
    always_comb begin
        unique case (fmt)
            AOCC_FMT_TWOS: data_nxt = code_twos;
            AOCC_FMT_GRAY: data_nxt = code_ob ^ (code_ob >> 1);
            default:       data_nxt = code_ob;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_o <= '0;
        end else begin
            data_o <= data_nxt;
        end
    end

    // self-test signature over the formatted data; the reset bit holds it cleared
    assign sig_nxt = {sig_r[14:0], ^(sig_r & AOCC_SIG_POLY)} ^ {2'h0, data_nxt};
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sig_r <= '0;
        end else if (self_test_r[AOCC_BIT_TEST_RST]) begin
            sig_r <= '0;
        end else if (self_test_r[AOCC_BIT_TEST_EN]) begin
            sig_r <= sig_nxt;
        end
    end

    // helper: cycles since the phase register was last written, saturating at 8
    logic [3:0] phase_age_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_age_r <= '0;
        end else if (reg_wr_i && reg_addr_i == AOCC_ADR_CLK_PHASE) begin
            phase_age_r <= '0;
        end else if (phase_age_r != 4'h8) begin
            phase_age_r <= phase_age_r + 4'h1;
        end
    end

    AST_TRIM_ZERO_PASS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (offset_r == 8'h00 && fmt == AOCC_FMT_TWOS && !out_mode_r[AOCC_BIT_INVERT])
        |=> data_o == {~$past(sample_i[13]), $past(sample_i[12:0])})
        else $error("zero trim altered the sample");
    AST_TRIM_SAT_HIGH: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (sample_i == 14'h3fff && !offset_r[7] && fmt == AOCC_FMT_TWOS
         && !out_mode_r[AOCC_BIT_INVERT]) |=> data_o == 14'h1fff)
        else $error("positive trim wrapped past full scale");
    AST_FMT_OB_TWOS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (fmt == AOCC_FMT_OFFSET_BIN || fmt == AOCC_FMT_OFFSET_BIN2)
        |=> data_o == {~$past(code_twos[13]), $past(code_twos[12:0])})
        else $error("offset binary output mismatch");
    AST_FMT_GRAY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        fmt == AOCC_FMT_GRAY |=> (data_o[13] == ~$past(code_twos[13]))
        && (data_o[12] == ($past(code_twos[13]) ^ ~$past(code_twos[12]))))
        else $error("gray output top bits mismatch");
    AST_PHASE_SEVEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (phase == 3'h7 && phase_age_r == 4'h8) |-> div_tick_o == $past(div_tick_i, 7))
        else $error("phase seven delay wrong");
    AST_PHASE_NONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        phase == 3'h0 |-> div_tick_o == div_tick_i)
        else $error("phase zero added delay");
    AST_DCLK_FULL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_delay_r[4:0] == 5'h1f [*2] |-> output_data_clock_delay_ps_o == 12'h9c4)
        else $error("full code delay not 2500 ps");
    AST_DCLK_ONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        clk_delay_r[4:0] == 5'h01 [*2] |-> output_data_clock_delay_ps_o == 12'h051)
        else $error("one code delay not 81 ps");
    AST_CMOS_DEFAULT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (lvds_mode_o && !$past(lvds_mode_o)) |->
        $past(reg_wr_i && reg_addr_i == AOCC_ADR_OUT_MODE && reg_wdata_i[AOCC_BIT_OUT_TYPE]))
        else $error("lvds entered without a write");

    COV_LVDS_ON: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(lvds_mode_o) ##[1:20] outputs_enable_o);
    COV_GRAY_OUT: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        fmt == AOCC_FMT_GRAY ##1 data_o != 14'h0000);
    COV_PHASE_TICK: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        phase == 3'h7 && div_tick_o);
    COV_SIG_RUN: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        sig_r[7:0] != 8'h00);

endmodule : aocc_regs

`default_nettype wire

/* File: test/aocc_host_model.sv */
// host model that masters the register port and the output disable pin
`timescale 1ns/1ns
`default_nettype none

module aocc_host_model
    import aocc_pkg::*;
(
    // clock
    input  wire logic                   clk_i,
    // register port
    output logic      [AOCC_ADDR_W-1:0] reg_addr_o,
    output logic      [AOCC_DATA_W-1:0] reg_wdata_o,
    output logic                        reg_wr_o,
    output logic                        reg_rd_o,
    input  wire logic [AOCC_DATA_W-1:0] reg_rdata_i,
    // output driver pin
    output logic                        output_disable_pin_o
);
    // outputs held off through power-up to avoid the cmos current into lvds loads
    initial begin
        reg_addr_o           = 13'h0000;
        reg_wdata_o          = 8'h00;
        reg_wr_o             = 1'b0;
        reg_rd_o             = 1'b0;
        output_disable_pin_o = 1'b1;
    end

    // one access: strobe for one edge, then scramble the released lines
    task automatic acc(input logic w, input logic [12:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge clk_i);
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = w;
        reg_rd_o    = ~w;
        @(negedge clk_i);
        q           = reg_rdata_i;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask

    // release the pin only once lvds has been programmed
    task automatic pin_low();
        @(negedge clk_i);
        output_disable_pin_o = 1'b0;
    endtask
endmodule // aocc_host_model

`default_nettype wire

/* File: test/aocc_regs_tb_top.sv */
// self-checking testbench of the configuration register bank
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end

module aocc_regs_tb_top
    import aocc_pkg::*;
;
    logic        clk = 1'b0, rst_n = 1'b0, wr, rd, pin, oe, lvds, swing, ilv;
    logic        tick = 1'b0, tick_q, dinv, servo;
    logic [12:0] addr;
    logic [7:0]  wdata, rdata, q;
    logic [13:0] smp = 14'h0000, dat;
    logic [11:0] dps;
    logic [1:0]  rr;
    int          n_mismatch = 0, n_checks = 0, cyc = 0;
    logic [12:0] adr[9] = '{13'h000e, 13'h000f, 13'h0010, 13'h0014, 13'h0016,
                            13'h0017, 13'h0018, 13'h0024, 13'h0011};
    logic [7:0]  rv[9]  = '{8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'h00, 8'h00};
    logic [7:0]  mk[9]  = '{8'h05, 8'h01, 8'hff, 8'hff, 8'h87, 8'h1f, 8'hc0, 8'h00, 8'h00};
    logic [13:0] sv[5]  = '{14'h2000, 14'h0000, 14'h3fff, 14'h1234, 14'h2abc};
    logic [7:0]  tv[5]  = '{8'h7f, 8'h80, 8'h7f, 8'hf6, 8'h00};
    int          dc[5]  = '{0, 1, 2, 30, 31};
    int          dp[5]  = '{0, 81, 161, 2419, 2500};

    always #2 clk = ~clk;

    aocc_host_model i_host (.clk_i(clk), .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_rdata_i(rdata), .output_disable_pin_o(pin));

    aocc_regs i_dut (.clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .sample_i(smp), .data_o(dat),
        .output_disable_pin_i(pin), .outputs_enable_o(oe), .lvds_mode_o(lvds),
        .reduced_swing_o(swing), .interleave_o(ilv), .div_tick_i(tick), .div_tick_o(tick_q),
        .output_data_clock_invert_o(dinv), .output_data_clock_delay_ps_o(dps),
        .servo_enable_o(servo), .ref_range_o(rr));

    // expected formatted sample: trim in twos complement, saturate, then encode
    function automatic logic [13:0] fmt_exp(logic [13:0] s, logic [7:0] t, logic [1:0] f,
                                            logic inv);
        int          v;
        logic [13:0] ob;
        v  = int'($signed({~s[13], s[12:0]})) + int'($signed(t));
        v  = (v > 8191) ? 8191 : ((v < -8192) ? -8192 : v);
        ob = (inv ? ~v[13:0] : v[13:0]) ^ 14'h2000;
        return (f == 2'h1) ? (ob ^ 14'h2000) : ((f == 2'h2) ? (ob ^ (ob >> 1)) : ob);
    endfunction

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // hang guard, generous against roughly 360 cycles of traffic
    always @(posedge clk) begin
        cyc++;
        if (cyc > 5000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (5) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        `CHK("lvds_rst", 1'b0, lvds)
        foreach (adr[i]) begin
            i_host.acc(1'b0, adr[i], 8'h00, q);
            `CHK("rst_val", rv[i], q)
        end
        // cmos first, outputs kept off by the pin until lvds is set
        `CHK("oe_pin_high", 1'b0, oe)
        i_host.acc(1'b1, 13'h0014, 8'h40, q);
        `CHK("lvds_set", 1'b1, lvds)
        i_host.pin_low();
        repeat (3) @(negedge clk);
        `CHK("oe_on", 1'b1, oe)
        // all ones everywhere, including the read-only and an unmapped place
        foreach (adr[i]) i_host.acc(1'b1, adr[i], 8'hff, q);
        foreach (adr[i]) begin
            i_host.acc(1'b0, adr[i], 8'h00, q);
            `CHK("mask", mk[i], q)
        end
        `CHK("outs", 8'h7f, {oe, lvds, swing, ilv, dinv, servo, rr})
        // trim, invert and every format code; bit 2 of f is the invert bit
        for (int f = 0; f < 8; f++) begin
            i_host.acc(1'b1, 13'h0014, 8'(f), q);
            foreach (sv[i]) begin
                i_host.acc(1'b1, 13'h0010, tv[i], q);
                @(negedge clk) smp = sv[i];
                @(negedge clk);
                `CHK("data", fmt_exp(sv[i], tv[i], 2'(f), f[2]), dat)
            end
        end
        // let the signature run on live data, then the reset bit must clear it
        i_host.acc(1'b1, 13'h000e, 8'h01, q);
        repeat (4) @(negedge clk);
        i_host.acc(1'b1, 13'h000e, 8'h05, q);
        i_host.acc(1'b0, 13'h0024, 8'h00, q);
        `CHK("sig_clr", 8'h00, q)
        // divider tick shows up exactly phase cycles later
        for (int p = 0; p < 8; p++) begin
            i_host.acc(1'b1, 13'h0016, 8'(p), q);
            @(negedge clk) tick = 1'b1;
            #1 `CHK("tick", p == 0, tick_q)
            for (int k = 1; k < 9; k++) begin
                @(negedge clk) tick = 1'b0;
                #1 `CHK("tick", p == k, tick_q)
            end
        end
        // output data clock delay scaling
        foreach (dc[i]) begin
            i_host.acc(1'b1, 13'h0017, 8'(dc[i]), q);
            @(negedge clk);
            `CHK("dly_ps", 12'(dp[i]), dps)
        end
        tally_and_finish();
    end
endmodule // aocc_regs_tb_top

`default_nettype wire
